/* File: src/idgp_map.vh */
// register addresses, field positions, reset values and encodings
// for the input divider and group power control block.
// assumes it is included by bare name from every design file that needs it.
`ifndef IDGP_MAP_VH
`define IDGP_MAP_VH

// ****************************************************************
// serial word layout
// ****************************************************************
`define IDGP_WORD_BITS 32
`define IDGP_ADDR_MSB 3
`define IDGP_ADDR_LSB 0

// ****************************************************************
// register addresses (low four bits of the serial word)
// ****************************************************************
`define IDGP_ADDR_INPUT_GROUP_CTRL 4'h0
`define IDGP_ADDR_GLOBAL_CTRL 4'h1
`define IDGP_ADDR_PAIR_DIV 4'h5
`define IDGP_ADDR_LOCK_CTRL 4'hf
`define IDGP_LOCK_LAST_ADDR 4'h5

// ****************************************************************
// field positions
// ****************************************************************
`define IDGP_SOFT_RESET_BIT 4
`define IDGP_GROUP_PD_LSB 6
`define IDGP_GROUP_PD_MSB 9
`define IDGP_BUF_A_BIT 10
`define IDGP_BUF_B_BIT 11
`define IDGP_PREDIV_A_LSB 14
`define IDGP_PREDIV_A_MSB 16
`define IDGP_SEL_A_LSB 17
`define IDGP_SEL_A_MSB 18
`define IDGP_PREDIV_B_LSB 19
`define IDGP_PREDIV_B_MSB 21
`define IDGP_SEL_B_LSB 22
`define IDGP_SEL_B_MSB 23
`define IDGP_GLOBAL_PD_BIT 5
`define IDGP_PAIR_DIV_LSB 17
`define IDGP_PAIR_DIV_MSB 27
`define IDGP_LOCK_BIT 4

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define IDGP_GROUP_PD_RST 4'h0
`define IDGP_BUF_RST 1'b0
`define IDGP_PREDIV_RST 3'h1
`define IDGP_SEL_RST 2'h0
`define IDGP_GLOBAL_PD_RST 1'b0
`define IDGP_PAIR_DIV_RST 11'h001
`define IDGP_LOCK_RST 1'b0
`define IDGP_SEL_DIVIDE 2'h1

`endif

/* File: src/idgp_serial_rx.v */
// serial configuration receiver: shifts data in on serial clock rising
// edges, msb first, and presents the word with a commit pulse when the
// latch enable pin rises. pins are asynchronous to clk; the serial
// clock must be well below clk/4 so every edge is seen.
`timescale 1ns/1ps
`include "idgp_map.vh"

module idgp_serial_rx
(
    input wire clk,
    input wire reset,
    input wire serial_clock_pin,
    input wire serial_data_pin,
    input wire serial_latch_enable,
    output reg [`IDGP_WORD_BITS-1:0] word_q,
    output reg commit_q
);

    reg [2:0] sclk_sync_q;
    reg [1:0] data_sync_q;
    reg [2:0] le_sync_q;
    reg [`IDGP_WORD_BITS-1:0] shift_q;

    // ****************************************************************
    // pin synchronisers; stage 0 feeds only stage 1
    // ****************************************************************
    always @(posedge clk)
    begin
        if (reset)
        begin
            sclk_sync_q <= 3'h0;
            data_sync_q <= 2'h0;
            le_sync_q <= 3'h0;
        end
        else
        begin
            sclk_sync_q <= {sclk_sync_q[1:0], serial_clock_pin};
            data_sync_q <= {data_sync_q[0], serial_data_pin};
            le_sync_q <= {le_sync_q[1:0], serial_latch_enable};
        end
    end

    // ****************************************************************
    // shift and commit
    // ****************************************************************
    always @(posedge clk)
    begin
        if (reset)
        begin
            shift_q <= {`IDGP_WORD_BITS{1'b0}};
            word_q <= {`IDGP_WORD_BITS{1'b0}};
            commit_q <= 1'b0;
        end
        else
        begin
            commit_q <= le_sync_q[1] & ~le_sync_q[2];
            if (sclk_sync_q[1] & ~sclk_sync_q[2])
                shift_q <= {shift_q[`IDGP_WORD_BITS-2:0], data_sync_q[1]};
            if (le_sync_q[1] & ~le_sync_q[2])
                word_q <= shift_q;
        end
    end

endmodule

/* File: src/idgp_clock_divider.v */
// edge-counting divider for a sampled clock level. a value of zero
// means the largest count 2**W. bypass or divide-by-1 passes the level.
// assumes clk_level is already synchronised to clk and well below clk/2.
`timescale 1ns/1ps

module idgp_clock_divider
#(
    parameter W = 3
)
(
    input wire clk,
    input wire reset,
    input wire enable,
    input wire clk_level,
    input wire [W-1:0] div_value,
    input wire divide_sel,
    output reg div_out_q
);

    reg prev_q;
    reg [W:0] count_q;
    reg [W:0] count_d;
    reg div_out_d;
    wire rise;
    wire [W:0] n_w;
    wire [W:0] last_w;
    wire [W:0] half_w;

    assign rise = clk_level & ~prev_q;
    // zero selects the full range so the field has no dead code
    assign n_w = (div_value == {W{1'b0}}) ? {1'b1, {W{1'b0}}} : {1'b0, div_value};
    assign last_w = n_w - {{W{1'b0}}, 1'b1};
    assign half_w = {1'b0, n_w[W:1]} + {{W{1'b0}}, n_w[0]};

    always @*
    begin
        count_d = count_q;
        if (!enable)
            count_d = {(W+1){1'b0}};
        else if (rise)
            count_d = (count_q >= last_w) ? {(W+1){1'b0}} : count_q + {{W{1'b0}}, 1'b1};
        if (!enable)
            div_out_d = 1'b0;
        else if (!divide_sel || n_w == {{W{1'b0}}, 1'b1})
            div_out_d = clk_level;
        else
            div_out_d = (count_d < half_w);
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            prev_q <= 1'b0;
            count_q <= {(W+1){1'b0}};
            div_out_q <= 1'b0;
        end
        else
        begin
            prev_q <= clk_level;
            count_q <= count_d;
            div_out_q <= div_out_d;
        end
    end

endmodule

/* File: src/idgp_top.v */
// input divider and group power control: serial configuration registers,
// soft reset, write lock, global and per-group power down, and the two
// input pre-dividers plus the output-pair divider.
// assumes one 10 MHz clk; all pins arrive asynchronously and are
// synchronised here or in the serial receiver.
//
// Functional notes
// RL1: committed word with soft-reset bit set restores every setting to default.
// RL2: a soft-reset write ignores all other fields of that word.
// RL3: soft-reset bit clears itself on the next committed write of any register.
// RL4: host should write soft-reset as zero when reprogramming later.
// RL5: global power-down bit one powers down the whole device, zero runs.
// RL6: settings kept during global power-down; clearing the bit resumes.
// RL7: four group power-down bits disable dividers and outputs of each group. Here a shared pre-divider stops only when every group it feeds is down.
// RL8: input buffer select per input: zero bipolar, one cmos.
// RL9: each input has a three-bit pre-divider value field.
// RL10: pre-divider value zero divides by eight, else by the value.
// RL11: path select zero bypasses the pre-divider, one divides.
// RL12: lock bit defaults writeable; when set registers zero to five ignore writes.
// RL13: eleven-bit pair output divider, default divide-by-one.
// RL14: undefined path select values two and three act as bypass.
`timescale 1ns/1ps
`include "idgp_map.vh"

module idgp_top
(
    clk,
    reset,
    serial_clock_pin,
    serial_data_pin,
    serial_latch_enable,
    input_a_clock,
    input_b_clock,
    group_clk_out,
    group_enable,
    global_power_down,
    input_a_buffer_select,
    input_b_buffer_select,
    config_write_lock,
    soft_reset_active
);

    input wire clk;
    input wire reset;
    input wire serial_clock_pin;
    input wire serial_data_pin;
    input wire serial_latch_enable;
    input wire input_a_clock;
    input wire input_b_clock;
    output reg [3:0] group_clk_out;
    output reg [3:0] group_enable;
    output reg global_power_down;
    output reg input_a_buffer_select;
    output reg input_b_buffer_select;
    output reg config_write_lock;
    output reg soft_reset_active;

    // ****************************************************************
    // declarations
    // ****************************************************************
    wire [`IDGP_WORD_BITS-1:0] word;
    wire commit;
    wire [3:0] addr;
    wire locked_target;
    wire sel_input_group;
    wire sel_global;
    wire sel_pair_div;
    wire sel_lock;
    wire soft_reset_req;

    reg soft_reset_q;
    reg [3:0] output_group_power_down_q;
    reg input_a_buffer_select_q;
    reg input_b_buffer_select_q;
    reg [2:0] input_a_predivide_value_q;
    reg [2:0] input_b_predivide_value_q;
    reg [1:0] input_a_path_select_q;
    reg [1:0] input_b_path_select_q;
    reg global_power_down_q;
    reg [10:0] pair_output_divider_q;
    reg config_write_lock_q;

    reg [1:0] clk_a_sync_q;
    reg [1:0] clk_b_sync_q;

    wire path_a_enable;
    wire path_b_enable;
    wire pair_enable;
    wire path_a_out;
    wire path_b_out;
    wire pair_out;
    wire [3:0] group_src;
    wire [3:0] group_on;

    // ****************************************************************
    // serial port
    // ****************************************************************
    idgp_serial_rx u_rx
    (
        .clk(clk),
        .reset(reset),
        .serial_clock_pin(serial_clock_pin),
        .serial_data_pin(serial_data_pin),
        .serial_latch_enable(serial_latch_enable),
        .word_q(word),
        .commit_q(commit)
    );

    assign addr = word[`IDGP_ADDR_MSB:`IDGP_ADDR_LSB];
    // the lock guards the low block only, so the lock itself stays reachable
    assign locked_target = config_write_lock_q && (addr <= `IDGP_LOCK_LAST_ADDR); // RL12

    // ****************************************************************
    // address decode
    // ****************************************************************
    // decoded once so the soft-reset priority over the other fields of
    // register zero is visible in one place; unmapped addresses decode to
    // nothing and only end a pending soft-reset flag
    assign sel_input_group = (addr == `IDGP_ADDR_INPUT_GROUP_CTRL);
    assign sel_global = (addr == `IDGP_ADDR_GLOBAL_CTRL);
    assign sel_pair_div = (addr == `IDGP_ADDR_PAIR_DIV);
    assign sel_lock = (addr == `IDGP_ADDR_LOCK_CTRL);
    assign soft_reset_req = sel_input_group & word[`IDGP_SOFT_RESET_BIT]; // RL1

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always @(posedge clk)
    begin
        if (reset)
        begin
            soft_reset_q <= 1'b0;
            output_group_power_down_q <= `IDGP_GROUP_PD_RST;
            input_a_buffer_select_q <= `IDGP_BUF_RST;
            input_b_buffer_select_q <= `IDGP_BUF_RST;
            input_a_predivide_value_q <= `IDGP_PREDIV_RST;
            input_b_predivide_value_q <= `IDGP_PREDIV_RST;
            input_a_path_select_q <= `IDGP_SEL_RST;
            input_b_path_select_q <= `IDGP_SEL_RST;
            global_power_down_q <= `IDGP_GLOBAL_PD_RST;
            pair_output_divider_q <= `IDGP_PAIR_DIV_RST; // RL13
            config_write_lock_q <= `IDGP_LOCK_RST; // RL12
        end
        else if (commit)
        begin
            // any later committed write drops the soft-reset flag
            soft_reset_q <= 1'b0; // RL3
            if (!locked_target)
            begin
                if (soft_reset_req)
                begin
                    // other fields of this word are discarded on purpose
                    soft_reset_q <= 1'b1; // RL1
                    output_group_power_down_q <= `IDGP_GROUP_PD_RST; // RL2
                    input_a_buffer_select_q <= `IDGP_BUF_RST;
                    input_b_buffer_select_q <= `IDGP_BUF_RST;
                    input_a_predivide_value_q <= `IDGP_PREDIV_RST;
                    input_b_predivide_value_q <= `IDGP_PREDIV_RST;
                    input_a_path_select_q <= `IDGP_SEL_RST;
                    input_b_path_select_q <= `IDGP_SEL_RST;
                    global_power_down_q <= `IDGP_GLOBAL_PD_RST;
                    pair_output_divider_q <= `IDGP_PAIR_DIV_RST;
                    config_write_lock_q <= `IDGP_LOCK_RST;
                end
                else if (sel_input_group)
                begin
                    output_group_power_down_q <=
                        word[`IDGP_GROUP_PD_MSB:`IDGP_GROUP_PD_LSB]; // RL7
                    input_a_buffer_select_q <= word[`IDGP_BUF_A_BIT]; // RL8
                    input_b_buffer_select_q <= word[`IDGP_BUF_B_BIT]; // RL8
                    input_a_predivide_value_q <=
                        word[`IDGP_PREDIV_A_MSB:`IDGP_PREDIV_A_LSB]; // RL9
                    input_b_predivide_value_q <=
                        word[`IDGP_PREDIV_B_MSB:`IDGP_PREDIV_B_LSB]; // RL9
                    input_a_path_select_q <= word[`IDGP_SEL_A_MSB:`IDGP_SEL_A_LSB]; // RL11
                    input_b_path_select_q <= word[`IDGP_SEL_B_MSB:`IDGP_SEL_B_LSB]; // RL11
                end
                else if (sel_global)
                begin
                    // only this bit lives here; neighbouring fields are not kept
                    global_power_down_q <= word[`IDGP_GLOBAL_PD_BIT]; // RL5
                end
                else if (sel_pair_div)
                begin
                    pair_output_divider_q <=
                        word[`IDGP_PAIR_DIV_MSB:`IDGP_PAIR_DIV_LSB]; // RL13
                end
                else if (sel_lock)
                begin
                    config_write_lock_q <= word[`IDGP_LOCK_BIT]; // RL12
                end
            end
        end
    end

    // ****************************************************************
    // input clock sampling
    // ****************************************************************
    // input clocks are sampled, so usable rates sit well below clk/2
    always @(posedge clk)
    begin
        if (reset)
        begin
            clk_a_sync_q <= 2'h0;
            clk_b_sync_q <= 2'h0;
        end
        else
        begin
            clk_a_sync_q <= {clk_a_sync_q[0], input_a_clock};
            clk_b_sync_q <= {clk_b_sync_q[0], input_b_clock};
        end
    end

    // ****************************************************************
    // dividers
    // ****************************************************************
    // a path runs while any group it feeds is on; global power down
    // only gates activity, the stored settings stay untouched
    assign group_on = ~output_group_power_down_q & {4{~global_power_down_q}}; // RL5 RL6 RL7
    assign path_a_enable = group_on[0] | group_on[1];
    assign path_b_enable = group_on[2] | group_on[3];
    assign pair_enable = group_on[3];

    idgp_clock_divider #(.W(3)) u_prediv_a
    (
        .clk(clk),
        .reset(reset),
        .enable(path_a_enable),
        .clk_level(clk_a_sync_q[1]),
        .div_value(input_a_predivide_value_q), // RL10
        .divide_sel(input_a_path_select_q == `IDGP_SEL_DIVIDE), // RL11 RL14
        .div_out_q(path_a_out)
    );

    idgp_clock_divider #(.W(3)) u_prediv_b
    (
        .clk(clk),
        .reset(reset),
        .enable(path_b_enable),
        .clk_level(clk_b_sync_q[1]),
        .div_value(input_b_predivide_value_q), // RL10
        .divide_sel(input_b_path_select_q == `IDGP_SEL_DIVIDE), // RL11 RL14
        .div_out_q(path_b_out)
    );

    idgp_clock_divider #(.W(11)) u_pair_div
    (
        .clk(clk),
        .reset(reset),
        .enable(pair_enable),
        .clk_level(path_b_out),
        .div_value(pair_output_divider_q), // RL13
        .divide_sel(1'b1),
        .div_out_q(pair_out)
    );

    // the pair divider counts edges of the already divided input b level,
    // so with input b path select at divide its overall ratio is the product of both divide values, and in bypass it is the pair value alone
    assign group_src = {pair_out, path_b_out, path_a_out, path_a_out};

    // ****************************************************************
    // group outputs
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_group
            always @(posedge clk)
            begin
                if (reset)
                begin
                    group_clk_out[gi] <= 1'b0;
                    group_enable[gi] <= 1'b0;
                end
                else
                begin
                    group_clk_out[gi] <= group_src[gi] & group_on[gi]; // RL7
                    group_enable[gi] <= group_on[gi]; // RL7
                end
            end
        end
    endgenerate

    // ****************************************************************
    // status outputs
    // ****************************************************************
    always @(posedge clk)
    begin
        if (reset)
        begin
            global_power_down <= 1'b0;
            input_a_buffer_select <= 1'b0;
            input_b_buffer_select <= 1'b0;
            config_write_lock <= 1'b0;
            soft_reset_active <= 1'b0;
        end
        else
        begin
            global_power_down <= global_power_down_q; // RL5
            input_a_buffer_select <= input_a_buffer_select_q; // RL8
            input_b_buffer_select <= input_b_buffer_select_q; // RL8
            config_write_lock <= config_write_lock_q;
            soft_reset_active <= soft_reset_q;
        end
    end

endmodule

/* File: tb/idgp_host_model.sv */
// host side model: shifts 32-bit words into the serial pins, msb first,
// then raises the latch enable to commit them.
// assumes the bench clock clk; pins change only on its falling edge.
`timescale 1ns/1ps
module idgp_host_model
(
    input wire clk,
    output logic serial_clock_pin,
    output logic serial_data_pin,
    output logic serial_latch_enable
);
    // ****************************************************************
    // word transfer
    // ****************************************************************
    initial
    begin
        serial_clock_pin = 1'b0;
        serial_data_pin = 1'b0;
        serial_latch_enable = 1'b0;
    end

    // spacing of 3+ clk cycles per phase, since every pin is synchronised
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--)
        begin
            @(negedge clk) serial_data_pin = w[i];
            repeat (3) @(negedge clk);
            serial_clock_pin = 1'b1;
            repeat (4) @(negedge clk);
            serial_clock_pin = 1'b0;
        end
        repeat (3) @(negedge clk);
        // data no longer held: show the inverse, not the stale bit
        serial_data_pin = ~serial_data_pin;
        serial_latch_enable = 1'b1;
        repeat (4) @(negedge clk);
        serial_latch_enable = 1'b0;
        repeat (12) @(negedge clk);
    endtask
endmodule

/* File: tb/idgp_top_chk.sv */
// port checker for the input divider and group power control top.
// assumes it is bound to idgp_top and sees only that module's ports.
`timescale 1ns/1ps
module idgp_chk
(
    input wire clk,
    input wire reset,
    input wire [3:0] group_clk_out,
    input wire [3:0] group_enable,
    input wire global_power_down,
    input wire input_a_buffer_select,
    input wire input_b_buffer_select,
    input wire config_write_lock,
    input wire soft_reset_active
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    reset_clear_a: assert property ($fell(reset) |-> group_enable == 4'h0 &&
        group_clk_out == 4'h0 && !config_write_lock && !soft_reset_active)
        else $error("outputs not cleared by reset");
    global_off_a: assert property (global_power_down |-> group_enable == 4'h0)
        else $error("group enabled during global power down");
    gated_clk_a: assert property ((group_enable == 4'h0)[*6] |-> group_clk_out == 4'h0)
        else $error("group clock runs while powered down");
    soft_default_a: assert property (soft_reset_active |-> !config_write_lock &&
        !global_power_down && !input_a_buffer_select && !input_b_buffer_select &&
        group_enable == 4'hf)
        else $error("soft reset left a non-default setting");
    lock_hold_a: assert property ((config_write_lock ##1 config_write_lock) |->
        $stable({input_a_buffer_select, input_b_buffer_select, global_power_down}))
        else $error("locked setting changed");
    locked_soft_a: assert property ($rose(soft_reset_active) |-> !$past(config_write_lock))
        else $error("soft reset taken while locked");
    rise_a_en_a: assert property ($rose(group_clk_out[1]) |-> group_enable[1])
        else $error("group 1 clock rose while off");
    rise_pair_en_a: assert property ($rose(group_clk_out[3]) |-> group_enable[3])
        else $error("pair clock rose while off");

    cover property ($rose(soft_reset_active));
    cover property ($rose(config_write_lock));
    cover property ($rose(global_power_down));
endmodule

bind idgp_top idgp_chk chk_u
(
    .clk(clk),
    .reset(reset),
    .group_clk_out(group_clk_out),
    .group_enable(group_enable),
    .global_power_down(global_power_down),
    .input_a_buffer_select(input_a_buffer_select),
    .input_b_buffer_select(input_b_buffer_select),
    .config_write_lock(config_write_lock),
    .soft_reset_active(soft_reset_active)
);

/* File: tb/tb.sv */
// self-checking bench for idgp_top: serial writes through the host model,
// status and clock-rate checks at the ports.
// assumes a 10 MHz clk and input clocks well below clk/4.
`timescale 1ns/1ps
module tb;
    // ****************************************************************
    // stimulus, observation and checks
    // ****************************************************************
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] icnt = 5'h00;
    logic meas = 1'b0;
    logic [3:0] prev_q = 4'h0;
    int ec[4];
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    wire sclk;
    wire sdata;
    wire sle;
    wire [3:0] group_clk_out;
    wire [3:0] group_enable;
    wire global_power_down;
    wire input_a_buffer_select;
    wire input_b_buffer_select;
    wire config_write_lock;
    wire soft_reset_active;
    wire [8:0] obs = {global_power_down, input_a_buffer_select, input_b_buffer_select,
        config_write_lock, soft_reset_active, group_enable};

    always #50 clk = ~clk;
    // input a period 16 clk cycles, input b period 32
    always @(negedge clk) icnt <= icnt + 5'h01;

    idgp_host_model host_u
    (
        .clk(clk),
        .serial_clock_pin(sclk),
        .serial_data_pin(sdata),
        .serial_latch_enable(sle)
    );
    idgp_top dut_u
    (
        .clk(clk),
        .reset(reset),
        .serial_clock_pin(sclk),
        .serial_data_pin(sdata),
        .serial_latch_enable(sle),
        .input_a_clock(icnt[3]),
        .input_b_clock(icnt[4]),
        .group_clk_out(group_clk_out),
        .group_enable(group_enable),
        .global_power_down(global_power_down),
        .input_a_buffer_select(input_a_buffer_select),
        .input_b_buffer_select(input_b_buffer_select),
        .config_write_lock(config_write_lock),
        .soft_reset_active(soft_reset_active)
    );

    always @(posedge clk)
    begin
        prev_q <= group_clk_out;
        for (int k = 0; k < 4; k++)
            if (!meas)
                ec[k] <= 0;
            else if (group_clk_out[k] === 1'b1 && prev_q[k] === 1'b0)
                ec[k] <= ec[k] + 1;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] word0(input logic [1:0] sa, input logic [2:0] da,
        input logic [1:0] sb, input logic [2:0] db);
        return {8'h00, sb, db, sa, da, 14'h0000};
    endfunction

    task automatic cmp_obs(input logic [8:0] exp);
        checked++;
        if (obs !== exp)
        begin
            err_total++;
            $display("Error %0t: status %h expected %h", $time, obs, exp);
        end
    endtask

    // edge counts over 1536 cycles: 96 periods of input a, 48 of input b
    task automatic cmp_rate(input int e0, input int e1, input int e2, input int e3);
        int ex[4];
        ex = '{e0, e1, e2, e3};
        meas = 1'b1;
        repeat (1536) @(negedge clk);
        meas = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            checked++;
            if ((ex[k] == 0) ? ec[k] != 0 : (ec[k] > ex[k] + 1 || ec[k] + 1 < ex[k]))
            begin
                err_total++;
                $display("Error %0t: group %0d edges %0d expected %0d", $time, k, ec[k], ex[k]);
            end
        end
    endtask

    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        cmp_obs(9'h00f);
        cmp_rate(96, 96, 48, 48);
        for (int i = 0; i < 4; i++)
        begin
            host_u.send(32'h00000040 << i);
            cmp_obs({5'h00, 4'hf & ~(4'h1 << i)});
        end
        host_u.send(32'h000003c0);
        cmp_rate(0, 0, 0, 0);
        host_u.send(32'h00000400);
        cmp_obs(9'h08f);
        host_u.send(32'h00000c00);
        cmp_obs(9'h0cf);
        host_u.send(32'h00000021);
        cmp_obs(9'h1c0);
        cmp_rate(0, 0, 0, 0);
        host_u.send(32'h00000001);
        cmp_obs(9'h0cf);
        host_u.send(word0(2'h1, 3'h0, 2'h1, 3'h3));
        cmp_rate(12, 12, 16, 16);
        host_u.send(word0(2'h1, 3'h7, 2'h1, 3'h1));
        cmp_rate(14, 14, 48, 48);
        host_u.send(word0(2'h2, 3'h5, 2'h3, 3'h5));
        cmp_rate(96, 96, 48, 48);
        host_u.send(word0(2'h0, 3'h5, 2'h1, 3'h6));
        cmp_rate(96, 96, 8, 8);
        host_u.send(32'h00060005);
        cmp_rate(96, 96, 8, 3);
        host_u.send(32'h00000021);
        host_u.send(32'h00fffff0);
        cmp_obs(9'h01f);
        cmp_rate(96, 96, 48, 48);
        host_u.send(32'h00000003);
        cmp_obs(9'h00f);
        host_u.send(32'h00000010);
        host_u.send(32'h00000000);
        cmp_obs(9'h00f);
        host_u.send(32'h0000001f);
        cmp_obs(9'h02f);
        host_u.send(32'h00000c40);
        host_u.send(32'h00000021);
        host_u.send(32'h00060005);
        cmp_obs(9'h02f);
        host_u.send(32'h0000000f);
        host_u.send(32'h00000c00);
        cmp_obs(9'h0cf);
        cmp_rate(96, 96, 48, 48);
        tally_and_finish();
    end
endmodule
